// *** logic/gain_loop_pkg.sv ***
// package: register map, field layout, reset values and types of the if gain loop
package gain_loop_pkg;

   // register byte offsets, one aligned word each
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_TARGET    = 8'h04;
   localparam logic [7:0] OFS_LOCK_THR  = 8'h08;
   localparam logic [7:0] OFS_LOCK_LEN  = 8'h0c;
   localparam logic [7:0] OFS_BANDWIDTH = 8'h10;
   localparam logic [7:0] OFS_STATUS    = 8'h14;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h1c;

   // control register field positions
   localparam int CTRL_SLOPE_PRI_BIT = 0;
   localparam int CTRL_SLOPE_SEC_BIT = 1;
   localparam int CTRL_SEC_EN_BIT    = 2;

   // bandwidth register field positions
   localparam int BW_WIDE_LSB   = 0;
   localparam int BW_NARROW_LSB = 4;

   // status register field positions
   localparam int STAT_LOCK_BIT  = 0;
   localparam int STAT_TRACK_BIT = 1;
   localparam int STAT_CTRL_LSB  = 16;

   // interrupt bit positions
   localparam int IRQ_LOCK_GAINED = 0;
   localparam int IRQ_LOCK_LOST   = 1;

   // reset values
   localparam logic [2:0]  CTRL_RST      = 3'h0;
   localparam logic [9:0]  TARGET_RST    = 10'h0c0;
   localparam logic [11:0] LOCK_THR_RST  = 12'h010;
   localparam logic [15:0] LOCK_LEN_RST  = 16'h0100;
   localparam logic [3:0]  BW_WIDE_RST   = 4'h6;
   localparam logic [3:0]  BW_NARROW_RST = 4'h2;
   localparam logic [1:0]  IRQ_MASK_RST  = 2'h0;

   // smoothing shift of the lock detector error average
   localparam int ERR_AVG_SHIFT = 3;

   // software configuration carried as one group
   typedef struct packed {
      logic sec_en;
      logic slope_sec;
      logic slope_pri;
   } loop_cfg_t;

   // loop status carried as one group
   typedef struct packed {
      logic       locked;
      logic       tracking;
      logic [9:0] ctrl;
   } loop_stat_t;

endpackage : gain_loop_pkg

// *** logic/sigma_delta_mod.sv ***
// first-order sigma-delta modulator turning a control word into a bit stream
`timescale 1ns/1ps
`default_nettype none

module sigma_delta_mod #(
   parameter int W = 10
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // control word in, bit stream out
   input  wire logic [W-1:0] level_i,
   output logic              bit_o
);

   logic [W-1:0] phase;
   logic [W:0]   sum;

   // carry out of the phase accumulator is the output bit; its density is level/2^W
   assign sum = {1'b0, phase} + {1'b0, level_i};

   // accumulator and registered output bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase <= '0;
         bit_o <= 1'b0;
      end else begin
         phase <= sum[W-1:0];
         bit_o <= sum[W];
      end
   end

endmodule : sigma_delta_mod

`default_nettype wire

// *** logic/if_gain_control_loop.sv ***
// if gain control loop: error, loop filter, lock detector, sigma-delta outputs, wishbone regs
// Notes on behaviour
// - loop works on 10-bit signed samples from the on-chip converter
// - each sample: magnitude minus programmable target gives signed error
// - error is integrated by a loop filter; result is the gain control value
// - control value leaves as a one-bit sigma-delta stream
// - target is software-writable so it can be lowered below default
// - per-output slope bit inverts the control sense; software matches amplifier
// - wide loop gain for acquisition, narrow loop gain for tracking
// - loop never frozen or reset by channel changes, it keeps running
// - lock indication derived from loop, shown to sequencer and software
// - downstream acquisition enabled only while gain lock is asserted
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module if_gain_control_loop
   import gain_loop_pkg::*;
#(
   parameter int SAMPLE_W = 10,
   parameter int ACC_W    = 21
) (
   // clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // wishbone slave
   input  wire logic                cyc_i,
   input  wire logic                stb_i,
   input  wire logic                we_i,
   input  wire logic [7:0]          adr_i,
   input  wire logic [3:0]          sel_i,
   input  wire logic [31:0]         dat_i,
   output logic [31:0]              dat_o,
   output logic                     ack_o,
   // converter samples
   input  wire logic [SAMPLE_W-1:0] sample_i,
   input  wire logic                sample_valid_i,
   // gain outputs, open drain
   output logic                     primary_gain_out_o,
   output logic                     primary_gain_out_oe_o,
   output logic                     secondary_gain_out_o,
   output logic                     secondary_gain_out_oe_o,
   // lock to sequencer and downstream stages
   output logic                     gain_locked_o,
   output logic                     acq_enable_o,
   // interrupt
   output logic                     irq_o
);

   localparam int ERR_W = SAMPLE_W + 2;

   // merge written bytes into a word under the byte enables
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction : merge_bytes

   // magnitude of a signed sample; the most negative code maps to 2^(W-1)
   function automatic logic [SAMPLE_W-1:0] sample_mag(input logic [SAMPLE_W-1:0] s);
      return s[SAMPLE_W-1] ? SAMPLE_W'(-s) : s;
   endfunction : sample_mag

   // magnitude of a signed error word
   function automatic logic [ERR_W-1:0] err_mag(input logic [ERR_W-1:0] e);
      return e[ERR_W-1] ? ERR_W'(-e) : e;
   endfunction : err_mag

   // ---------------- register storage ----------------
   loop_cfg_t           cfg;
   logic [SAMPLE_W-1:0] target;
   logic [11:0]         lock_thr;
   logic [15:0]         lock_len;
   logic [3:0]          bw_wide;
   logic [3:0]          bw_narrow;
   logic [1:0]          irq_stat;
   logic [1:0]          irq_mask;

   // ---------------- loop state ----------------
   logic signed [ERR_W-1:0] err;
   logic signed [ERR_W-1:0] err_avg;
   logic                    err_ok;
   logic signed [ACC_W-1:0] acc;
   logic [15:0]             run_cnt;
   logic                    locked;
   logic                    tracking;
   logic                    s1_valid;

   // ---------------- wishbone decode ----------------
   logic        req;
   logic        wr_take;
   logic [31:0] wr_word;
   logic [31:0] rd_word;
   logic        hit_ctrl;
   logic        hit_target;
   logic        hit_thr;
   logic        hit_len;
   logic        hit_bw;
   logic        hit_stat;
   logic        hit_istat;
   logic        hit_imask;

   // a write lands on the edge that raises ack, so exactly once per request
   assign req       = cyc_i & stb_i & ~ack_o;
   assign wr_take   = req & we_i;
   assign hit_ctrl   = (adr_i == OFS_CTRL);
   assign hit_target = (adr_i == OFS_TARGET);
   assign hit_thr    = (adr_i == OFS_LOCK_THR);
   assign hit_len    = (adr_i == OFS_LOCK_LEN);
   assign hit_bw     = (adr_i == OFS_BANDWIDTH);
   assign hit_stat   = (adr_i == OFS_STATUS);
   assign hit_istat  = (adr_i == OFS_IRQ_STAT);
   assign hit_imask  = (adr_i == OFS_IRQ_MASK);

   // current register image, used for byte merging and for reads
   logic [31:0] img_ctrl;
   logic [31:0] img_target;
   logic [31:0] img_thr;
   logic [31:0] img_len;
   logic [31:0] img_bw;
   logic [31:0] img_stat;
   logic [31:0] img_istat;
   logic [31:0] img_imask;

   assign img_ctrl   = {29'h0, cfg};
   assign img_target = {22'h0, target};
   assign img_thr    = {20'h0, lock_thr};
   assign img_len    = {16'h0, lock_len};
   assign img_bw     = {24'h0, bw_narrow, bw_wide};
   assign img_stat   = {6'h0, acc[ACC_W-2 -: SAMPLE_W], 14'h0, tracking, locked};
   assign img_istat  = {30'h0, irq_stat};
   assign img_imask  = {30'h0, irq_mask};

   // read mux; unmapped addresses answer with zero
   assign rd_word = hit_ctrl   ? img_ctrl   :
                    hit_target ? img_target :
                    hit_thr    ? img_thr    :
                    hit_len    ? img_len    :
                    hit_bw     ? img_bw     :
                    hit_stat   ? img_stat   :
                    hit_istat  ? img_istat  :
                    hit_imask  ? img_imask  : 32'h0;

   // write data merged with the addressed register under sel
   assign wr_word = merge_bytes(rd_word, dat_i, sel_i);

   // bus answer: ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end else begin
         ack_o <= req;
         dat_o <= (req & ~we_i) ? rd_word : 32'h0;
      end
   end

   // configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg       <= CTRL_RST;
         target    <= TARGET_RST;
         lock_thr  <= LOCK_THR_RST;
         lock_len  <= LOCK_LEN_RST;
         bw_wide   <= BW_WIDE_RST;
         bw_narrow <= BW_NARROW_RST;
         irq_mask  <= IRQ_MASK_RST;
      end else if (wr_take) begin
         if (hit_ctrl)   cfg      <= loop_cfg_t'(wr_word[2:0]);
         if (hit_target) target   <= wr_word[SAMPLE_W-1:0];
         if (hit_thr)    lock_thr <= wr_word[11:0];
         if (hit_len)    lock_len <= wr_word[15:0];
         if (hit_imask)  irq_mask <= wr_word[1:0];
         if (hit_bw) begin
            bw_wide   <= wr_word[BW_WIDE_LSB +: 4];
            bw_narrow <= wr_word[BW_NARROW_LSB +: 4];
         end
      end
   end

   // ---------------- error path ----------------
   logic signed [ERR_W-1:0] next_err;
   logic signed [ERR_W:0]   avg_step;
   logic signed [ERR_W-1:0] next_err_avg;

   // magnitude minus target, both zero-extended so the sign is honest
   assign next_err = $signed({2'b00, sample_mag(sample_i)})
                   - $signed({2'b00, target});

   // leaky average of the error, what the lock detector watches
   // the difference is made signed so a negative error shifts arithmetically
   assign avg_step     = $signed({err[ERR_W-1], err} - {err_avg[ERR_W-1], err_avg})
                       >>> ERR_AVG_SHIFT;
   assign next_err_avg = ERR_W'(err_avg + avg_step[ERR_W-1:0]);

   // first stage: register the error; second: average it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err      <= '0;
         err_avg  <= '0;
         s1_valid <= 1'b0;
      end else begin
         s1_valid <= sample_valid_i;
         if (sample_valid_i) err <= next_err;
         if (s1_valid) err_avg <= next_err_avg;
      end
   end

   // ---------------- loop filter ----------------
   logic [3:0]              gain_shift;
   logic signed [ACC_W-1:0] err_wide;
   logic signed [ACC_W-1:0] delta;
   logic signed [ACC_W:0]   acc_sum;
   logic signed [ACC_W-1:0] next_acc;
   localparam logic signed [ACC_W-1:0] ACC_MAX = {2'b00, {(ACC_W-2){1'b1}}};

   // bandwidth follows the tracking flag
   assign gain_shift = tracking ? bw_narrow : bw_wide;
   assign err_wide   = ACC_W'(err);
   assign delta      = err_wide <<< gain_shift;
   // too large a signal gives positive error, so the gain request drops
   assign acc_sum    = {acc[ACC_W-1], acc} - {delta[ACC_W-1], delta};
   // clamp to the unsigned control range instead of wrapping round
   assign next_acc   = acc_sum[ACC_W] ? '0 :
                       (acc_sum > {1'b0, ACC_MAX}) ? ACC_MAX : acc_sum[ACC_W-1:0];

   // integrator; deliberately no freeze or clear input, it runs across retunes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc <= '0;
      end else if (s1_valid) begin
         acc <= next_acc;
      end
   end

   // ---------------- lock detector ----------------
   logic run_full;
   logic lock_rise;
   logic lock_fall;

   // a sample argues for lock when the magnitude of the averaged error is below lock_thr
   assign err_ok   = (err_mag(err_avg) < lock_thr);
   assign run_full = (run_cnt >= lock_len);
   assign lock_rise = s1_valid & ~locked & err_ok & run_full;
   assign lock_fall = s1_valid & locked & ~err_ok & run_full;

   // run length of samples that argue for a change of lock state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_cnt <= 16'h0;
      end else if (lock_rise | lock_fall) begin
         run_cnt <= 16'h0;
      end else if (s1_valid) begin
         if (err_ok ^ locked) begin
            run_cnt <= run_full ? run_cnt : run_cnt + 16'h1;
         end else begin
            run_cnt <= 16'h0;
         end
      end
   end

   // lock and tracking flags; a lock length of zero changes on first disagreeing sample
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         locked   <= 1'b0;
         tracking <= 1'b0;
      end else begin
         if (lock_rise) begin
            locked   <= 1'b1;
            tracking <= 1'b1;
         end else if (lock_fall) begin
            locked   <= 1'b0;
            tracking <= 1'b0;
         end
      end
   end

   // ---------------- interrupts ----------------
   logic [1:0] irq_set;
   logic [1:0] irq_clr;

   assign irq_set = {lock_fall, lock_rise};
   assign irq_clr = (wr_take & hit_istat) ? wr_word[1:0] : 2'b00;

   // sticky status; a new event beats a write-one-to-clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= 2'b00;
         irq_o    <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
         irq_o    <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
      end
   end

   // ---------------- outputs ----------------
   loop_stat_t  stat;
   logic [9:0]  pri_level;
   logic [9:0]  sec_level;
   logic        pri_bit;
   logic        sec_bit;

   assign stat.locked   = locked;
   assign stat.tracking = tracking;
   assign stat.ctrl     = acc[ACC_W-2 -: SAMPLE_W];

   // slope bits flip the control sense for amplifiers with falling gain
   assign pri_level = stat.ctrl ^ {SAMPLE_W{cfg.slope_pri}};
   assign sec_level = stat.ctrl ^ {SAMPLE_W{cfg.slope_sec}};

   sigma_delta_mod #(
      .W       (SAMPLE_W)
   ) u_pri_mod (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .level_i (pri_level),
      .bit_o   (pri_bit)
   );

   sigma_delta_mod #(
      .W       (SAMPLE_W)
   ) u_sec_mod (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .level_i (sec_level),
      .bit_o   (sec_bit)
   );

   // open drain: pull low for a zero, release for a one (external pull-up and rc)
   assign primary_gain_out_o      = 1'b0;
   assign primary_gain_out_oe_o   = ~pri_bit;
   assign secondary_gain_out_o    = 1'b0;
   assign secondary_gain_out_oe_o = cfg.sec_en & ~sec_bit;

   // downstream stages wait for gain lock
   assign gain_locked_o = stat.locked;
   assign acq_enable_o  = stat.locked;

endmodule : if_gain_control_loop

`default_nettype wire

// *** tb/gain_amp_model.sv ***
// amplifier side model: rc filter seen as a count of high pin cycles
`timescale 1ns/1ps
`default_nettype none

module gain_amp_model (
   // clock and window restart
   input  wire logic   clk_i,
   input  wire logic   clear_i,
   // pin levels after the pull-up
   input  wire logic   pri_pin_i,
   input  wire logic   sec_pin_i,
   // filtered levels, high cycles per window
   output logic [11:0] pri_avg_o,
   output logic [11:0] sec_avg_o
);
   // boxcar stands in for the rc low-pass: only the density of ones counts
   always_ff @(posedge clk_i) begin
      pri_avg_o <= clear_i ? 12'h0 : pri_avg_o + 12'(pri_pin_i);
      sec_avg_o <= clear_i ? 12'h0 : sec_avg_o + 12'(sec_pin_i);
   end
endmodule : gain_amp_model

`default_nettype wire

// *** tb/if_gain_control_loop_asserts.sv ***
// concurrent checks on the ports of the if gain control loop
`timescale 1ns/1ps
`default_nettype none

module if_gain_control_loop_asserts
   import gain_loop_pkg::*;
(
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // register bus
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // samples and pins
   input wire logic        sample_valid_i,
   input wire logic        primary_gain_out_o,
   input wire logic        secondary_gain_out_o,
   // lock and interrupt
   input wire logic        gain_locked_o,
   input wire logic        acq_enable_o,
   input wire logic        irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // bus handshake: one cycle answer, one cycle pulse
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing after request");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   a_unmapped_zero: assert property (ack_o && $past(!we_i && adr_i > OFS_IRQ_MASK)
      |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   // status mirrors the lock level, tracking follows lock
   a_status_lock: assert property (ack_o && $past(!we_i && adr_i == OFS_STATUS)
      |-> dat_o[STAT_LOCK_BIT] == $past(gain_locked_o)
      && dat_o[STAT_TRACK_BIT] == dat_o[STAT_LOCK_BIT])
      else $error("status lock or tracking wrong");
   a_acq_gate: assert property (acq_enable_o == gain_locked_o)
      else $error("acquisition enable differs from lock");
   // lock moves only on the edge after a taken sample, so it is seen changed two edges after it
   a_lock_cause: assert property ($changed(gain_locked_o) |-> $past(sample_valid_i, 2))
      else $error("lock changed without sample");
   a_drive_low: assert property (!primary_gain_out_o && !secondary_gain_out_o)
      else $error("open drain data not low");

   // main scenarios reached
   c_lock_gained: cover property ($rose(gain_locked_o));
   c_lock_lost: cover property ($fell(gain_locked_o));
   c_irq_seen: cover property ($rose(irq_o));
endmodule : if_gain_control_loop_asserts

bind if_gain_control_loop if_gain_control_loop_asserts u_if_gain_control_loop_asserts (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .sample_valid_i(sample_valid_i),
   .primary_gain_out_o(primary_gain_out_o), .secondary_gain_out_o(secondary_gain_out_o),
   .gain_locked_o(gain_locked_o), .acq_enable_o(acq_enable_o), .irq_o(irq_o)
);

`default_nettype wire

// *** tb/if_gain_control_loop_bench.sv ***
// self-checking bench of the if gain control loop
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end

module if_gain_control_loop_bench
   import gain_loop_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        req = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] rdat, q;
   logic        ack, sv = 1'b0, clr = 1'b0;
   logic [9:0]  smp = 10'h0;
   logic        pri_o, pri_oe, sec_o, sec_oe, locked, acq, irq;
   logic [11:0] pri_avg, sec_avg;
   int          errors = 0, checks_done = 0, cycles = 0;
   // pull-up on both open-drain pins
   wire logic   pri_pin = pri_oe ? pri_o : 1'b1;
   wire logic   sec_pin = sec_oe ? sec_o : 1'b1;

   always #20 clk_i = ~clk_i;

   if_gain_control_loop u_if_gain_control_loop (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(req), .stb_i(req), .we_i(we), .adr_i(adr),
      .sel_i(4'hf), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .sample_i(smp),
      .sample_valid_i(sv), .primary_gain_out_o(pri_o), .primary_gain_out_oe_o(pri_oe),
      .secondary_gain_out_o(sec_o), .secondary_gain_out_oe_o(sec_oe),
      .gain_locked_o(locked), .acq_enable_o(acq), .irq_o(irq));

   gain_amp_model u_gain_amp_model (.clk_i(clk_i), .clear_i(clr), .pri_pin_i(pri_pin),
      .sec_pin_i(sec_pin), .pri_avg_o(pri_avg), .sec_avg_o(sec_avg));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   // hang guard, the tests need some 3340 cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 10000) begin
         errors++;
         give_verdict();
      end
   end

   // classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      req <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      `CHK("ack", 1'b1, ack)
      req <= 1'b0;
   endtask : wb

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK("register", e, q)
   endtask : rc

   // one sample, then room for lock flags and interrupt to settle
   task automatic send(input logic [9:0] s);
      @(posedge clk_i);
      smp <= s;
      sv  <= 1'b1;
      @(posedge clk_i);
      sv  <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : send

   task automatic measure();
      @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      repeat (1025) @(posedge clk_i);
   endtask : measure

   function automatic logic near(input logic [11:0] v, input int e);
      return int'(v) >= e - 2 && int'(v) <= e + 2;
   endfunction : near

   task automatic t_reset();
      `CHK("oe after reset", 1'b1, pri_oe)
      `CHK("lock after reset", 1'b0, locked)
      rc(OFS_CTRL, 32'(CTRL_RST));
      rc(OFS_TARGET, 32'(TARGET_RST));
      rc(OFS_LOCK_THR, 32'(LOCK_THR_RST));
      rc(OFS_LOCK_LEN, 32'(LOCK_LEN_RST));
      rc(OFS_BANDWIDTH, 32'({BW_NARROW_RST, BW_WIDE_RST}));
      rc(OFS_STATUS, 32'h0);
      rc(OFS_IRQ_STAT, 32'h0);
      rc(OFS_IRQ_MASK, 32'(IRQ_MASK_RST));
      wb(1'b1, 8'h20, 32'hffffffff);
      rc(8'h20, 32'h0);
      $display("test reset done");
   endtask : t_reset

   // five matching samples of both signs lock, four do not
   task automatic t_acquire();
      wb(1'b1, OFS_LOCK_LEN, 32'h4);
      wb(1'b1, OFS_TARGET, 32'h0b0);
      rc(OFS_TARGET, 32'h0b0);
      wb(1'b1, OFS_IRQ_MASK, 32'h1);
      for (int i = 0; i < 4; i++) send(i[0] ? 10'h0b0 : 10'h350);
      `CHK("early lock", 1'b0, locked)
      `CHK("early acq", 1'b0, acq)
      send(10'h350);
      `CHK("lock", 1'b1, locked)
      `CHK("acq", 1'b1, acq)
      `CHK("irq gained", 1'b1, irq)
      rc(OFS_STATUS, 32'h3);
      wb(1'b1, OFS_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clk_i);
      `CHK("irq cleared", 1'b0, irq)
      $display("test acquire done");
   endtask : t_acquire

   // error 0xb0 below target: 6 narrow steps of 704 until lock drops, then 18 wide of 11264
   // lock is judged on the average before each sample, so the first zero sample still agrees
   task automatic t_loss();
      for (int i = 0; i < 4; i++) send(10'h0);
      rc(OFS_STATUS, 32'h0002_0003);
      for (int i = 0; i < 20; i++) send(10'h0);
      rc(OFS_STATUS, 32'h00ca_0000);
      `CHK("acq off", 1'b0, acq)
      `CHK("masked irq", 1'b0, irq)
      rc(OFS_IRQ_STAT, 32'h2);
      wb(1'b1, OFS_IRQ_MASK, 32'h3);
      repeat (2) @(posedge clk_i);
      `CHK("irq lost", 1'b1, irq)
      wb(1'b1, OFS_IRQ_STAT, 32'h2);
      repeat (2) @(posedge clk_i);
      `CHK("irq lost cleared", 1'b0, irq)
      $display("test loss done");
   endtask : t_loss

   // control 202 seen by the amplifier, inverted per output by its own slope bit
   task automatic t_density();
      wb(1'b1, OFS_CTRL, 32'h5);
      measure();
      `CHK("primary inverted", 1'b1, near(pri_avg, 821))
      `CHK("secondary density", 1'b1, near(sec_avg, 202))
      wb(1'b1, OFS_CTRL, 32'h6);
      measure();
      `CHK("primary plain", 1'b1, near(pri_avg, 202))
      `CHK("secondary inverted", 1'b1, near(sec_avg, 821))
      wb(1'b1, OFS_CTRL, 32'h0);
      measure();
      `CHK("primary density", 1'b1, near(pri_avg, 202))
      `CHK("secondary released", 12'd1024, sec_avg)
      $display("test density done");
   endtask : t_density

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_acquire();
      t_loss();
      t_density();
      give_verdict();
   end
endmodule : if_gain_control_loop_bench

`default_nettype wire
